// ### rtl/dmc_pkg.sv
// Function
// - Sync one-zero-zero locks carrier detected.
// - No transition 1 to 1.5 bits drops carrier.
// - Activity light on any message, off at end.
// - Transmit bit clock square wave, 18 us period.
// - Idle when disabled; send data bits when enabled.
// - Receive clock low unlocked, toggles when locked.
// - Received data high idle, toggles ones, low zeros.
// - Signal-lost flag high when line has no signal.
// - Four indicators lit at power-up, show test number.
// - Single dark indicator steps on background loop.
package dmc_pkg;
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned BIT_NS        = 18000;
  localparam int unsigned BIT_CYC       = BIT_NS / 25;
  localparam int unsigned HALF_CYC      = BIT_CYC / 2;
  localparam int unsigned QTR_CYC       = BIT_CYC / 4;
  localparam int unsigned DROP_CYC      = (BIT_CYC * 5) / 4;
  localparam logic [11:0] HALF_CNT      = 12'(HALF_CYC - 1);
  localparam logic [11:0] DROP_CNT      = 12'(DROP_CYC);
  localparam logic [11:0] QTR_CNT       = 12'(QTR_CYC);
  localparam logic [11:0] SIG_CNT       = 12'(2 * BIT_CYC);
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0]  ADDR_LED      = 8'h10;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_STEP_BIT = 2;
  localparam logic [3:0]  LED_RESET     = 4'hF;
  localparam logic [3:0]  RING_START    = 4'hE;
  localparam int unsigned EV_LOCK       = 0;
  localparam int unsigned EV_DROP       = 1;
  localparam int unsigned EV_LOST       = 2;
  typedef enum logic [1:0] {
    DMC_LED_POWERUP,
    DMC_LED_TEST,
    DMC_LED_RUN
  } dmc_led_mode_t;
  typedef enum logic [1:0] {
    DMC_RX_HUNT,
    DMC_RX_ONE,
    DMC_RX_ZERO1,
    DMC_RX_LOCK
  } dmc_rx_state_t;
endpackage

// ### rtl/dmc_rx_if.sv
`timescale 1ns/10ps
interface dmc_rx_if;
  logic carrier;
  logic lock_pulse;
  logic drop_pulse;
  logic signal_lost;
  modport rx  (output carrier, output lock_pulse, output drop_pulse, output signal_lost);
  modport top (input carrier, input lock_pulse, input drop_pulse, input signal_lost);
endinterface

// ### rtl/dmc_rx.sv
`timescale 1ns/10ps
// Receiver: line coded so a one is a mid-bit transition, a zero is none.
module dmc_rx import dmc_pkg::*; (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic line_s,
  input  wire logic line_edge,
  dmc_rx_if.rx      rif,
  output logic      rx_clock,
  output logic      rx_data
);
  dmc_rx_state_t state;
  dmc_rx_state_t next_state;
  logic [11:0]   quiet;
  logic [11:0]   phase;
  logic          seen_edge;
  logic          lost;
  wire           bit_end   = (phase == 12'(BIT_CYC - 1));
  wire           half_tick = (phase == HALF_CNT) || bit_end;
  // Only an edge in the middle half of a bit marks a one; bit-start edges only frame the bit.
  wire           mid_edge  = line_edge && (phase >= QTR_CNT)
                             && (phase <= 12'(BIT_CYC - QTR_CYC));
  wire           bit_one   = seen_edge || mid_edge;
  wire           drop      = (quiet >= DROP_CNT);
  always_comb begin
    next_state = state;
    unique case (state)
      DMC_RX_HUNT:  if (bit_end && bit_one) next_state = DMC_RX_ONE;
      DMC_RX_ONE:   if (bit_end) next_state = bit_one ? DMC_RX_ONE : DMC_RX_ZERO1;
      DMC_RX_ZERO1: if (bit_end) next_state = bit_one ? DMC_RX_ONE : DMC_RX_LOCK;
      DMC_RX_LOCK:  next_state = DMC_RX_LOCK;
    endcase
    if (drop) next_state = DMC_RX_HUNT;
  end
  assign rif.carrier     = (state == DMC_RX_LOCK);
  assign rif.signal_lost = lost;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= DMC_RX_HUNT;
      quiet      <= SIG_CNT;
      phase      <= '0;
      seen_edge  <= 1'b0;
      lost       <= 1'b1;
      rx_clock   <= 1'b0;
      rx_data    <= 1'b1;
      rif.lock_pulse <= 1'b0;
      rif.drop_pulse <= 1'b0;
    end else begin
      state          <= next_state;
      rif.lock_pulse <= (next_state == DMC_RX_LOCK) && (state != DMC_RX_LOCK);
      rif.drop_pulse <= (state == DMC_RX_LOCK) && (next_state != DMC_RX_LOCK);
      quiet          <= line_edge ? 12'h000 : ((quiet >= SIG_CNT) ? quiet : quiet + 12'h001);
      lost           <= (quiet >= SIG_CNT);
      phase          <= (line_edge && (phase < QTR_CNT || phase > 12'(BIT_CYC - QTR_CYC)))
                        ? 12'h000 : (bit_end ? 12'h000 : phase + 12'h001);
      seen_edge      <= bit_end ? 1'b0 : (seen_edge || mid_edge);
      if (next_state != DMC_RX_LOCK) rx_clock <= 1'b0;
      else if (half_tick) rx_clock <= ~rx_clock;
      // A one shows high in its second half, so a run of ones is a bit-period square wave.
      if (drop) rx_data <= 1'b1;
      else if (mid_edge) rx_data <= 1'b1;
      else if (bit_end) rx_data <= 1'b0;
    end
  end
endmodule

// ### rtl/dmc_top.sv
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module dmc_top import dmc_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tx_key_on_n,
  input  wire logic        tx_data,
  input  wire logic        line_in,
  output logic             line_out,
  output logic             line_oe_n,
  output logic             tx_clock,
  output logic             rx_clock,
  output logic             rx_data,
  output logic             carrier_led,
  output logic             line_signal_lost,
  output logic [3:0]       status_led,
  output logic             irq
);
  dmc_rx_if      rif ();
  logic [2:0]    line_sync;
  logic [1:0]    key_sync;
  logic [1:0]    dat_sync;
  logic [11:0]   div;
  logic          cur_bit;
  logic [1:0]    led_mode;
  logic [3:0]    test_num;
  logic [3:0]    ring;
  logic [2:0]    irq_stat;
  logic [2:0]    irq_mask;
  logic          lost_q;
  logic          aw_held;
  logic          w_held;
  logic [7:0]    aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  wire           line_edge = line_sync[2] ^ line_sync[1];
  wire           tx_key_on = ~key_sync[1];
  wire           bit_end   = (div == 12'(BIT_CYC - 1));
  wire           half_end  = (div == HALF_CNT) || bit_end;
  wire           do_write  = aw_held && w_held && !s_axi_bvalid;
  wire           wr_ok     = w_strb[0];
  wire [2:0]     ev        = {rif.signal_lost && !lost_q, rif.drop_pulse, rif.lock_pulse};
  wire [2:0]     w_clr     = (do_write && wr_ok && aw_addr == ADDR_IRQ_STAT) ? w_data[2:0] : 3'h0;
  wire           w_ok_addr = (aw_addr == ADDR_CTRL) || (aw_addr == ADDR_IRQ_STAT)
                             || (aw_addr == ADDR_IRQ_MASK) || (aw_addr == ADDR_LED);
  wire           r_ok_addr = (s_axi_araddr == ADDR_CTRL) || (s_axi_araddr == ADDR_STATUS)
                             || (s_axi_araddr == ADDR_IRQ_STAT)
                             || (s_axi_araddr == ADDR_IRQ_MASK) || (s_axi_araddr == ADDR_LED);
  wire [31:0]    r_word    = (s_axi_araddr == ADDR_CTRL)     ? {30'h0, led_mode} :
                             (s_axi_araddr == ADDR_STATUS)   ? {28'h0, rif.signal_lost,
                                                                tx_key_on, carrier_led,
                                                                rif.carrier} :
                             (s_axi_araddr == ADDR_IRQ_STAT) ? {29'h0, irq_stat} :
                             (s_axi_araddr == ADDR_IRQ_MASK) ? {29'h0, irq_mask} :
                             (s_axi_araddr == ADDR_LED)      ? {28'h0, test_num} : 32'h0;
  dmc_rx u_rx (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .line_s    (line_sync[1]),
    .line_edge (line_edge),
    .rif       (rif),
    .rx_clock  (rx_clock),
    .rx_data   (rx_data)
  );
  assign carrier_led      = rif.carrier;
  assign line_signal_lost = rif.signal_lost;
  assign line_oe_n        = ~tx_key_on;
  assign irq              = |(irq_stat & irq_mask);
  assign s_axi_awready    = !aw_held;
  assign s_axi_wready     = !w_held;
  assign s_axi_arready    = !s_axi_rvalid;
  assign status_led = (led_mode == 2'(DMC_LED_POWERUP)) ? LED_RESET :
                      (led_mode == 2'(DMC_LED_TEST))    ? test_num : ring;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Reset to the idle line level so no false edge follows reset.
      line_sync <= 3'h7;
      key_sync  <= 2'h3;
      dat_sync  <= 2'h3;
    end else begin
      line_sync <= {line_sync[1:0], line_in};
      key_sync  <= {key_sync[0], tx_key_on_n};
      dat_sync  <= {dat_sync[0], tx_data};
    end
  end
  // Transmitter: each bit starts with a transition, a one adds one mid-bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div      <= '0;
      tx_clock <= 1'b0;
      line_out <= 1'b0;
      cur_bit  <= 1'b1;
    end else begin
      div <= bit_end ? 12'h000 : div + 12'h001;
      if (half_end) tx_clock <= ~tx_clock;
      if (bit_end) cur_bit <= dat_sync[1];
      if (!tx_key_on) line_out <= 1'b0;
      else if (bit_end || (div == HALF_CNT && cur_bit)) line_out <= ~line_out;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_mode <= 2'(DMC_LED_POWERUP);
      test_num <= LED_RESET;
      ring     <= RING_START;
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
      lost_q   <= 1'b1;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= '0;
      w_data   <= '0;
      w_strb   <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= '0;
    end else begin
      lost_q   <= rif.signal_lost;
      irq_stat <= (irq_stat & ~w_clr) | ev;
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_ok_addr ? 2'h0 : 2'h2;
        if (wr_ok && aw_addr == ADDR_CTRL) begin
          led_mode <= w_data[1:0];
          if (w_data[CTRL_STEP_BIT]) ring <= {ring[2:0], ring[3]};
        end
        if (wr_ok && aw_addr == ADDR_IRQ_MASK) irq_mask <= w_data[2:0];
        if (wr_ok && aw_addr == ADDR_LED) test_num <= w_data[3:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= r_word;
        s_axi_rresp  <= r_ok_addr ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ### dv/dmc_top_props.sv
`timescale 1ns/10ps
module dmc_top_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_key_on_n,
  input wire logic line_in,
  input wire logic line_oe_n,
  input wire logic tx_clock,
  input wire logic rx_clock,
  input wire logic rx_data,
  input wire logic carrier_led,
  input wire logic line_signal_lost,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [11:0] ecnt;
  logic [11:0] tcnt;
  logic [11:0] rhi;
  logic        li_q;
  logic        tx_q;
  logic        seen;
  // Quiet time on the line, tx clock phase length and rx clock high time.
  always_ff @(posedge aclk) begin
    li_q <= line_in;
    tx_q <= tx_clock;
    if (!aresetn || line_in != li_q) ecnt <= 12'h000;
    else if (ecnt != 12'hFFF) ecnt <= ecnt + 12'h001;
    if (!aresetn || tx_clock != tx_q) tcnt <= 12'h000;
    else tcnt <= tcnt + 12'h001;
    if (!aresetn) seen <= 1'b0;
    else if (tx_clock != tx_q) seen <= 1'b1;
    if (!rx_clock) rhi <= 12'h000;
    else rhi <= rhi + 12'h001;
  end
  sequence s_key_press;
    $fell(tx_key_on_n) ##1 !tx_key_on_n;
  endsequence
  sequence s_edge_while_lost;
    (line_in != li_q) && line_signal_lost;
  endsequence
  property p_reset;
    disable iff (1'b0) !aresetn |=> !rx_clock && rx_data && line_oe_n && line_signal_lost && !irq;
  endproperty
  property p_key_on;
    s_key_press |-> ##[0:730] !line_oe_n;
  endproperty
  property p_tx_half;
    (tx_clock != tx_q) && seen |-> tcnt == 12'h167;
  endproperty
  property p_rx_high;
    rx_clock |-> rhi < 12'h168;
  endproperty
  property p_lost_rxclk;
    line_signal_lost |-> !rx_clock;
  endproperty
  property p_quiet_drop;
    ecnt >= 12'h43D |-> !rx_clock;
  endproperty
  property p_quiet_lost;
    ecnt >= 12'h5A4 |-> line_signal_lost;
  endproperty
  property p_edge_clears;
    s_edge_while_lost |-> ##[1:6] !line_signal_lost;
  endproperty
  property p_led;
    line_signal_lost |-> !carrier_led;
  endproperty
  property p_idle_data;
    line_signal_lost |-> rx_data;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  a_key_on: assert property (p_key_on) else $error("key not on line");
  a_tx_half: assert property (p_tx_half) else $error("tx clock half period");
  a_rx_high: assert property (p_rx_high) else $error("rx clock high too long");
  a_lost_rxclk: assert property (p_lost_rxclk) else $error("rx clock without signal");
  a_quiet_drop: assert property (p_quiet_drop) else $error("carrier held on quiet");
  a_quiet_lost: assert property (p_quiet_lost) else $error("lost flag missing");
  a_edge_clears: assert property (p_edge_clears) else $error("lost flag stuck");
  a_led: assert property (p_led) else $error("activity light on without signal");
  a_idle_data: assert property (p_idle_data) else $error("rx data low idle");
endmodule
bind dmc_top dmc_top_props u_dmc_top_props (.aclk, .aresetn, .tx_key_on_n, .line_in, .line_oe_n,
  .tx_clock, .rx_clock, .rx_data, .carrier_led, .line_signal_lost, .irq);

// ### dv/dmc_line_model.sv
`timescale 1ns/10ps
module dmc_line_model (
  input  wire logic line_out,
  input  wire logic line_oe_n,
  output logic      line_in
);
  // The shared line is biased to one when no station drives it.
  assign line_in = line_oe_n ? 1'b1 : line_out;
endmodule

// ### dv/testbench.sv
`timescale 1ns/10ps
module testbench import dmc_pkg::*;;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, tx_key_on_n, tx_data, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, line_in, line_out, line_oe_n, tx_clock, rx_clock;
  logic        rx_data, carrier_led, line_signal_lost, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb, status_led;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
  logic [3:0]  k_n = 4'h8, t_d = 4'hD, e_car = 4'h6, e_lost = 4'h8;
  int          n_mismatch, samples_checked, cyc, nc, nd, m;
  dmc_top u_dmc_top (.*);
  dmc_line_model u_dmc_line_model (.line_out, .line_oe_n, .line_in);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Counts edges of both receive outputs over two bit times.
  task automatic count_tog();
    logic pc, pd;
    nc = 0;
    nd = 0;
    repeat (1440) begin
      pc = rx_clock;
      pd = rx_data;
      @(posedge aclk);
      nc += int'(rx_clock != pc);
      nd += int'(rx_data != pd);
    end
  endtask
  initial begin
    void'($urandom(32'hC492CE02));
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h0, 4'hF};
    {tx_key_on_n, tx_data, aresetn} = 3'h6;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_STATUS);
    chk(rd_d, 32'h8);
    chk(32'(status_led), 32'(LED_RESET));
    rd(8'h20);
    chk({rd_d[29:0], rd_r}, 32'h2);
    wr(ADDR_IRQ_STAT, 32'h7);
    for (int p = 0; p < 4; p++) begin
      tx_key_on_n <= k_n[p];
      tx_data <= t_d[p];
      repeat (720 * (4 + $urandom % 3)) @(posedge aclk);
      count_tog();
      chk(nc, e_car[p] ? 4 : 0);
      chk(nd, (t_d[p] && !k_n[p]) ? 4 : 0);
      rd(ADDR_STATUS);
      chk(rd_d, 32'({e_lost[p], !k_n[p], e_car[p], e_car[p]}));
      chk(32'(carrier_led), 32'(e_car[p]));
      if (p == 1) begin
        m = $urandom % 8;
        wr(ADDR_IRQ_MASK, m);
        rd(ADDR_IRQ_STAT);
        chk(rd_d, 32'h1);
        chk(32'(irq), 32'(m[0]));
        wr(ADDR_IRQ_STAT, 32'h1);
        wr(ADDR_IRQ_MASK, 32'h7);
        chk(32'(irq), 32'h0);
      end
    end
    rd(ADDR_IRQ_STAT);
    chk(rd_d, 32'h6);
    chk(32'(irq), 32'h1);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_LED, 32'h5);
    chk(32'(status_led), 32'h5);
    wr(ADDR_CTRL, 32'h2);
    chk(32'(status_led), 32'(RING_START));
    wr(ADDR_CTRL, 32'h6);
    chk(32'(status_led), 32'hD);
    report_and_stop();
  end
endmodule
